// [common/irq_power_reset_control_defs.vh]
// Constants for the interrupt, power and reset control block
`ifndef IRQ_POWER_RESET_CONTROL_DEFS_VH
`define IRQ_POWER_RESET_CONTROL_DEFS_VH
`define ADDR_POWER_CONTROL    8'h87
`define ADDR_TIMER_IRQ_CTRL   8'h88
`define ADDR_AUX_CONTROL      8'h8e
`define ADDR_IRQ_ENABLE       8'ha8
`define ADDR_IRQ_PRIORITY     8'hb8
`define ADDR_EXT_IRQ_CONTROL  8'hc0
`define RST_POWER_CONTROL     8'h30
`define RST_ZERO              8'h00
`define RST_PORTS             8'hff
`define RST_STACK_POINTER     8'h07
`define PWR_HALT_CORE_BIT     0
`define PWR_POWER_DOWN_BIT    1
`define PWR_KEEP_BIT          4
`define AUX_STROBE_DIS_BIT    0
`define TIMER_IRQ_CONTROL_IT0_BIT          0
`define TIMER_IRQ_CONTROL_IE0_BIT          1
`define TIMER_IRQ_CONTROL_IT1_BIT          2
`define TIMER_IRQ_CONTROL_IE1_BIT          3
`define IE_GLOBAL_BIT         7
`define XI_EDGE2_BIT          0
`define XI_FLAG2_BIT          1
`define XI_EN2_BIT            2
`define XI_PRIO2_BIT          3
`define XI_EDGE3_BIT          4
`define XI_FLAG3_BIT          5
`define XI_EN3_BIT            6
`define XI_PRIO3_BIT          7
`define VEC_BASE              8'h03
`define VEC_STEP              8'h08
`define OSC_PER_MACHINE       4'd12
`define STATE5_PHASE2_TICK    4'd9
`define RESET_MACHINE_CYCLES  2'd2
`define RESET_FILTER_LEN      3'd4
`endif

// [src/irq_power_reset_control.v]
// Interrupt arbitration, power management and reset control core block
`include "irq_power_reset_control_defs.vh"
module irq_power_reset_control (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       reset_pin,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_write,
  input  wire       bit_write,
  input  wire [2:0] bit_index,
  input  wire       bit_value,
  input  wire       ext_irq_0_pin,
  input  wire       ext_irq_1_pin,
  input  wire       port4_pin2,
  input  wire       port4_pin3,
  input  wire       timer0_req,
  input  wire       timer1_req,
  input  wire       serial_req,
  input  wire       timer2_req,
  input  wire       irq_ack,
  input  wire       irq_return,
  input  wire       latch_strobe_in,
  output reg  [7:0] sfr_rdata,
  output reg        irq_request,
  output reg  [7:0] irq_vector,
  output reg        core_clk_en,
  output reg        periph_clk_en,
  output reg        osc_enable,
  output reg        latch_strobe,
  output reg        core_reset,
  output reg  [7:0] port_reset_value,
  output reg  [7:0] stack_reset_value
);
  reg  [7:0] power_control_reg;
  reg  [7:0] timer_irq_control_reg;
  reg  [7:0] aux_control_reg;
  reg  [7:0] irq_enable_reg;
  reg  [7:0] irq_priority_reg;
  reg  [7:0] ext_irq_control_reg;
  reg        div2_reg;
  reg  [3:0] phase_reg;
  reg  [2:0] filt_reg;
  reg        filt_level_reg;
  reg  [1:0] held_reg;
  reg        int_reset_reg;
  reg        ext2_prev_reg;
  reg        ext3_prev_reg;
  reg        in_high_reg;
  reg        in_low_reg;
  reg  [2:0] taken_idx_reg;
  wire       ext2_in = port4_pin3;
  wire       ext3_in = port4_pin2;
  wire       any_reset = rst | int_reset_reg;
  wire [7:0] req;
  wire [7:0] high;
  reg  [2:0] hi_idx;
  reg  [2:0] lo_idx;
  reg        hi_any;
  reg        lo_any;
  integer    i;
  // Sources in polling order
  assign req[0] = irq_enable_reg[0] & timer_irq_control_reg[`TIMER_IRQ_CONTROL_IE0_BIT];
  assign req[1] = irq_enable_reg[1] & timer0_req;
  assign req[2] = irq_enable_reg[2] & timer_irq_control_reg[`TIMER_IRQ_CONTROL_IE1_BIT];
  assign req[3] = irq_enable_reg[3] & timer1_req;
  assign req[4] = irq_enable_reg[4] & serial_req;
  assign req[5] = irq_enable_reg[5] & timer2_req;
  assign req[6] = ext_irq_control_reg[`XI_EN2_BIT] & ext_irq_control_reg[`XI_FLAG2_BIT];
  assign req[7] = ext_irq_control_reg[`XI_EN3_BIT] & ext_irq_control_reg[`XI_FLAG3_BIT];
  assign high = {ext_irq_control_reg[`XI_PRIO3_BIT], ext_irq_control_reg[`XI_PRIO2_BIT],
                 irq_priority_reg[5:0]};
  // Fixed polling within each level
  always @*
  begin
    hi_idx = 3'd0;
    lo_idx = 3'd0;
    hi_any = 1'b0;
    lo_any = 1'b0;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (req[i] & high[i])
      begin
        hi_idx = i[2:0];
        hi_any = 1'b1;
      end
      if (req[i] & ~high[i])
      begin
        lo_idx = i[2:0];
        lo_any = 1'b1;
      end
    end
  end
  wire       global_en = irq_enable_reg[`IE_GLOBAL_BIT];
  wire       take_hi = global_en & hi_any & ~in_high_reg;
  wire       take_lo = global_en & lo_any & ~in_high_reg & ~in_low_reg;
  wire       pend = take_hi | take_lo;
  wire [2:0] sel_idx = take_hi ? hi_idx : lo_idx;
  wire       lvl_wake = (irq_enable_reg[0] & ~timer_irq_control_reg[`TIMER_IRQ_CONTROL_IT0_BIT]
                         & ~ext_irq_0_pin) |
                        (irq_enable_reg[2] & ~timer_irq_control_reg[`TIMER_IRQ_CONTROL_IT1_BIT]
                         & ~ext_irq_1_pin);
  wire       tick = (phase_reg == `STATE5_PHASE2_TICK) & div2_reg;
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      div2_reg       <= 1'b0;
      phase_reg      <= 4'd0;
      filt_reg       <= 3'd0;
      filt_level_reg <= 1'b0;
      held_reg       <= 2'd0;
      int_reset_reg  <= 1'b0;
    end
    else
    begin
      div2_reg <= ~div2_reg;
      if (div2_reg)
        phase_reg <= (phase_reg == `OSC_PER_MACHINE - 4'd1) ? 4'd0 : phase_reg + 4'd1;
      filt_reg <= {filt_reg[1:0], reset_pin};
      if (&{filt_reg, reset_pin})
        filt_level_reg <= 1'b1;
      else if (~|{filt_reg, reset_pin})
        filt_level_reg <= 1'b0;
      if (tick)
      begin
        if (!filt_level_reg)
        begin
          held_reg      <= 2'd0;
          int_reset_reg <= 1'b0;
        end
        else if (held_reg == `RESET_MACHINE_CYCLES - 2'd1)
          int_reset_reg <= 1'b1;
        else
          held_reg <= held_reg + 2'd1;
      end
    end
  end
  always @(posedge ref_clk)
  begin
    if (any_reset)
    begin
      power_control_reg     <= `RST_POWER_CONTROL;
      timer_irq_control_reg <= `RST_ZERO;
      aux_control_reg       <= `RST_ZERO;
      irq_enable_reg        <= `RST_ZERO;
      irq_priority_reg      <= `RST_ZERO;
      ext_irq_control_reg   <= `RST_ZERO;
      ext2_prev_reg         <= 1'b1;
      ext3_prev_reg         <= 1'b1;
      in_high_reg           <= 1'b0;
      in_low_reg            <= 1'b0;
      taken_idx_reg         <= 3'd0;
    end
    else
    begin
      ext2_prev_reg <= ext2_in;
      ext3_prev_reg <= ext3_in;
      if (sfr_write)
      begin
        case (sfr_addr)
          `ADDR_POWER_CONTROL:   power_control_reg     <= sfr_wdata;
          `ADDR_TIMER_IRQ_CTRL:  timer_irq_control_reg <= sfr_wdata;
          `ADDR_AUX_CONTROL:     aux_control_reg       <= sfr_wdata;
          `ADDR_IRQ_ENABLE:      irq_enable_reg        <= sfr_wdata;
          `ADDR_IRQ_PRIORITY:    irq_priority_reg      <= sfr_wdata;
          `ADDR_EXT_IRQ_CONTROL: ext_irq_control_reg   <= sfr_wdata;
          default: ;
        endcase
      end
      if (bit_write)
      begin
        case (sfr_addr)
          `ADDR_TIMER_IRQ_CTRL:  timer_irq_control_reg[bit_index] <= bit_value;
          `ADDR_IRQ_ENABLE:      irq_enable_reg[bit_index]        <= bit_value;
          `ADDR_IRQ_PRIORITY:    irq_priority_reg[bit_index]      <= bit_value;
          `ADDR_EXT_IRQ_CONTROL: ext_irq_control_reg[bit_index]   <= bit_value;
          default: ;
        endcase
      end
      // Hardware flag updates, set wins over software clear
      if (ext_irq_control_reg[`XI_EDGE2_BIT])
      begin
        if (irq_ack & pend & sel_idx == 3'd6)
          ext_irq_control_reg[`XI_FLAG2_BIT] <= 1'b0;
        if (ext2_prev_reg & ~ext2_in & ext_irq_control_reg[`XI_EN2_BIT])
          ext_irq_control_reg[`XI_FLAG2_BIT] <= 1'b1;
      end
      else
        ext_irq_control_reg[`XI_FLAG2_BIT] <= ~ext2_in;
      if (ext_irq_control_reg[`XI_EDGE3_BIT])
      begin
        if (irq_ack & pend & sel_idx == 3'd7)
          ext_irq_control_reg[`XI_FLAG3_BIT] <= 1'b0;
        if (ext3_prev_reg & ~ext3_in & ext_irq_control_reg[`XI_EN3_BIT])
          ext_irq_control_reg[`XI_FLAG3_BIT] <= 1'b1;
      end
      else
        ext_irq_control_reg[`XI_FLAG3_BIT] <= ~ext3_in;
      timer_irq_control_reg[`TIMER_IRQ_CONTROL_IE0_BIT] <= ~ext_irq_0_pin;
      timer_irq_control_reg[`TIMER_IRQ_CONTROL_IE1_BIT] <= ~ext_irq_1_pin;
      if (irq_ack & pend)
      begin
        taken_idx_reg <= sel_idx;
        if (take_hi)
          in_high_reg <= 1'b1;
        else
          in_low_reg <= 1'b1;
        power_control_reg[`PWR_HALT_CORE_BIT] <= 1'b0;
      end
      else if (irq_return)
      begin
        if (in_high_reg)
          in_high_reg <= 1'b0;
        else
          in_low_reg <= 1'b0;
      end
      if (power_control_reg[`PWR_POWER_DOWN_BIT] & lvl_wake)
        power_control_reg[`PWR_POWER_DOWN_BIT] <= 1'b0;
    end
  end
  // Outputs registered
  always @(posedge ref_clk)
  begin
    if (any_reset)
    begin
      sfr_rdata         <= `RST_ZERO;
      irq_request       <= 1'b0;
      irq_vector        <= `VEC_BASE;
      core_clk_en       <= 1'b0;
      periph_clk_en     <= 1'b0;
      osc_enable        <= 1'b1;
      latch_strobe      <= 1'b0;
      core_reset        <= 1'b1;
      port_reset_value  <= `RST_PORTS;
      stack_reset_value <= `RST_STACK_POINTER;
    end
    else
    begin
      case (sfr_addr)
        `ADDR_POWER_CONTROL:   sfr_rdata <= power_control_reg;
        `ADDR_TIMER_IRQ_CTRL:  sfr_rdata <= timer_irq_control_reg;
        `ADDR_AUX_CONTROL:     sfr_rdata <= aux_control_reg;
        `ADDR_IRQ_ENABLE:      sfr_rdata <= irq_enable_reg;
        `ADDR_IRQ_PRIORITY:    sfr_rdata <= irq_priority_reg;
        `ADDR_EXT_IRQ_CONTROL: sfr_rdata <= ext_irq_control_reg;
        default:               sfr_rdata <= `RST_ZERO;
      endcase
      irq_request   <= pend;
      irq_vector    <= `VEC_BASE + {2'b00, sel_idx, 3'b000};
      core_clk_en   <= ~div2_reg & ~power_control_reg[`PWR_HALT_CORE_BIT]
                       & ~power_control_reg[`PWR_POWER_DOWN_BIT];
      periph_clk_en <= ~div2_reg & ~power_control_reg[`PWR_POWER_DOWN_BIT];
      osc_enable    <= ~power_control_reg[`PWR_POWER_DOWN_BIT];
      latch_strobe  <= latch_strobe_in & ~aux_control_reg[`AUX_STROBE_DIS_BIT];
      core_reset    <= 1'b0;
    end
  end
endmodule // irq_power_reset_control

// [verif/irq_power_reset_control_chk.sv]
// Assertion checker for the interrupt, power and reset control block
module irq_power_reset_control_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reset_pin,
  input wire logic       latch_strobe_in,
  input wire logic       irq_ack,
  input wire logic       irq_request,
  input wire logic [7:0] irq_vector,
  input wire logic       core_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_enable,
  input wire logic       latch_strobe,
  input wire logic       core_reset,
  input wire logic [7:0] port_reset_value,
  input wire logic [7:0] stack_reset_value
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_div2;
    periph_clk_en |=> !periph_clk_en;
  endproperty
  a_div2: assert property (p_div2) else $error("clock enable not halved");
  property p_core;
    core_clk_en |-> periph_clk_en;
  endproperty
  a_core: assert property (p_core) else $error("core clocked alone");
  property p_wake;
    irq_ack ##1 !irq_ack |-> ##[1:4] core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("core not woken");
  property p_pdown;
    !osc_enable |-> !periph_clk_en && !core_clk_en;
  endproperty
  a_pdown: assert property (p_pdown) else $error("clock while stopped");
  property p_strobe;
    latch_strobe |-> $past(latch_strobe_in);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without cause");
  property p_rst_len;
    $rose(core_reset) |-> $past(reset_pin, 4) && $past(reset_pin);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset too short");
  property p_glitch;
    !core_reset && !reset_pin ##1 reset_pin ##1 !reset_pin |-> !core_reset [*8];
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch reset");
  property p_rvals;
    core_reset |-> port_reset_value == 8'hff && stack_reset_value == 8'h07;
  endproperty
  a_rvals: assert property (p_rvals) else $error("reset values wrong");
  property p_quiet;
    core_reset && $past(core_reset) |-> !irq_request;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request in reset");
  property p_vec;
    irq_request |-> irq_vector[2:0] == 3'h3 && irq_vector <= 8'h3b;
  endproperty
  a_vec: assert property (p_vec) else $error("vector off table");
  c_ext2: cover property (irq_request && irq_vector == 8'h33);
  c_idle: cover property (periph_clk_en && !core_clk_en);
  c_pd: cover property (!osc_enable);
endmodule // irq_power_reset_control_chk
bind irq_power_reset_control irq_power_reset_control_chk irq_power_reset_control_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .reset_pin(reset_pin), .latch_strobe_in(latch_strobe_in),
  .irq_ack(irq_ack), .irq_request(irq_request), .irq_vector(irq_vector),
  .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
  .latch_strobe(latch_strobe), .core_reset(core_reset),
  .port_reset_value(port_reset_value), .stack_reset_value(stack_reset_value));

// [verif/irq_src.sv]
// Model of the interrupt pins, peripheral requests and reset source
module irq_src (
  input  wire logic       ref_clk,
  output logic      [3:0] pin_n,
  output logic      [3:0] req,
  output logic            reset_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pin_n = 4'hf;
    req = 4'h0;
    reset_pin = 1'h0;
  end
  task automatic set_pin(input int i, input logic v);
    @(posedge ref_clk);
    pin_n[i] <= v;
  endtask
  task automatic set_req(input logic [3:0] v);
    @(posedge ref_clk);
    req <= v;
  endtask
  // Reset pin held high for k cycles
  task automatic hold_reset(input int k);
    @(posedge ref_clk);
    reset_pin <= 1'h1;
    repeat (k) @(posedge ref_clk);
    reset_pin <= 1'h0;
  endtask
endmodule // irq_src

// [verif/irq_power_reset_control_tb.sv]
// Testbench for the interrupt, power and reset control block
module irq_power_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, rst, sfr_write, bit_write, bit_value;
  logic       irq_ack, irq_return, latch_strobe_in, p;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_vector;
  logic [7:0] port_reset_value, stack_reset_value;
  logic [2:0] bit_index;
  logic       reset_pin, ext_irq_0_pin, ext_irq_1_pin, port4_pin2, port4_pin3;
  logic       timer0_req, timer1_req, serial_req, timer2_req, irq_request;
  logic       core_clk_en, periph_clk_en, osc_enable, latch_strobe, core_reset;
  logic [3:0] pin_n, req;
  int         bad_count = 0, checked = 0, n;
  assign {port4_pin3, port4_pin2, ext_irq_1_pin, ext_irq_0_pin} = pin_n;
  assign {timer2_req, serial_req, timer1_req, timer0_req} = req;
  irq_power_reset_control irq_power_reset_control_inst (
    .ref_clk(ref_clk), .rst(rst), .reset_pin(reset_pin), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .bit_write(bit_write),
    .bit_index(bit_index), .bit_value(bit_value), .ext_irq_0_pin(ext_irq_0_pin),
    .ext_irq_1_pin(ext_irq_1_pin), .port4_pin2(port4_pin2), .port4_pin3(port4_pin3),
    .timer0_req(timer0_req), .timer1_req(timer1_req), .serial_req(serial_req),
    .timer2_req(timer2_req), .irq_ack(irq_ack), .irq_return(irq_return),
    .latch_strobe_in(latch_strobe_in), .sfr_rdata(sfr_rdata), .irq_request(irq_request),
    .irq_vector(irq_vector), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .osc_enable(osc_enable), .latch_strobe(latch_strobe), .core_reset(core_reset),
    .port_reset_value(port_reset_value), .stack_reset_value(stack_reset_value));
  irq_src irq_src_inst (.ref_clk(ref_clk), .pin_n(pin_n), .req(req), .reset_pin(reset_pin));
  always #20 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, d, input logic b, input logic [2:0] i);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    bit_index <= i;
    bit_value <= d[0];
    sfr_write <= !b;
    bit_write <= b;
    @(posedge ref_clk);
    sfr_write <= 1'h0;
    bit_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    @(posedge ref_clk);
    #1 chk(sfr_rdata, exp);
  endtask
  task automatic wait_req(input logic [7:0] v);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    while (irq_request !== 1'h1 && n < 200);
    if (n >= 200)
    begin
      bad_count++;
      end_sim;
    end
    else
      chk(irq_vector, v);
  endtask
  task automatic ack(input logic a, r);
    @(posedge ref_clk);
    irq_ack <= a;
    @(posedge ref_clk);
    irq_ack <= 1'h0;
    irq_return <= r;
    @(posedge ref_clk);
    irq_return <= 1'h0;
  endtask
  task automatic t_regs;
    logic [7:0] a [6] = '{8'h87, 8'h88, 8'h8e, 8'ha8, 8'hb8, 8'hc0};
    for (int i = 0; i < 6; i++)
      rd(a[i], i ? 8'h00 : 8'h30);
    rd(8'h90, 8'h00);
    chk(port_reset_value, 8'hff);
    chk(stack_reset_value, 8'h07);
  endtask
  task automatic t_ext;
    wr(8'ha8, 8'h80, 0, 0);
    irq_src_inst.set_pin(3, 1'h0);
    cyc(4);
    #1 chk({7'h0, irq_request}, 8'h00);
    irq_src_inst.set_pin(3, 1'h1);
    wr(8'hc0, 8'h01, 0, 0);
    wr(8'hc0, 8'h01, 1, 2);
    irq_src_inst.set_pin(3, 1'h0);
    wait_req(8'h33);
    rd(8'hc0, 8'h07);
    ack(1'h1, 1'h1);
    rd(8'hc0, 8'h05);
    irq_src_inst.set_pin(2, 1'h0);
    wr(8'hc0, 8'hc4, 0, 0);
    wait_req(8'h3b);
    ack(1'h1, 1'h1);
    irq_src_inst.set_pin(2, 1'h1);
    irq_src_inst.set_pin(3, 1'h1);
    wr(8'hc0, 8'h00, 0, 0);
  endtask
  task automatic t_poll;
    logic [7:0] v [4] = '{8'h0b, 8'h1b, 8'h23, 8'h2b};
    wr(8'ha8, 8'hba, 0, 0);
    irq_src_inst.set_req(4'hf);
    for (int i = 0; i < 4; i++)
    begin
      wait_req(v[i]);
      ack(1'h1, 1'h1);
      irq_src_inst.set_req(4'he << i);
    end
    wr(8'hb8, 8'h20, 0, 0);
    irq_src_inst.set_req(4'h1);
    wait_req(8'h0b);
    ack(1'h1, 1'h0);
    irq_src_inst.set_req(4'h8);
    wait_req(8'h2b);
    ack(1'h1, 1'h1);
    irq_src_inst.set_req(4'h0);
    ack(1'h0, 1'h1);
    wr(8'hb8, 8'h00, 0, 0);
  endtask
  task automatic t_strobe;
    @(posedge ref_clk);
    latch_strobe_in <= 1'h1;
    wr(8'h8e, 8'h01, 0, 0);
    cyc(2);
    #1 chk({7'h0, latch_strobe}, 8'h00);
    wr(8'h8e, 8'h00, 0, 0);
    cyc(2);
    #1 chk({7'h0, latch_strobe}, 8'h01);
  endtask
  task automatic t_idle;
    wr(8'ha8, 8'h81, 0, 0);
    wr(8'h87, 8'h31, 0, 0);
    cyc(4);
    #1 p = periph_clk_en;
    repeat (6)
    begin
      @(posedge ref_clk);
      #1 chk({6'h0, core_clk_en, periph_clk_en ^ p}, 8'h01);
      p = periph_clk_en;
    end
    irq_src_inst.set_pin(0, 1'h0);
    wait_req(8'h03);
    ack(1'h1, 1'h1);
    irq_src_inst.set_pin(0, 1'h1);
    #1 p = core_clk_en;
    @(posedge ref_clk);
    #1 chk({7'h0, core_clk_en ^ p}, 8'h01);
  endtask
  task automatic t_pdown;
    irq_src_inst.hold_reset(1);
    cyc(30);
    #1 chk({7'h0, core_reset}, 8'h00);
    wr(8'ha8, 8'h84, 0, 0);
    wr(8'h87, 8'h32, 0, 0);
    cyc(3);
    #1 chk({6'h0, osc_enable, periph_clk_en}, 8'h00);
    irq_src_inst.set_pin(1, 1'h0);
    wait_req(8'h13);
    #1 chk({7'h0, osc_enable}, 8'h01);
    irq_src_inst.set_pin(1, 1'h1);
    rd(8'h87, 8'h30);
    wr(8'h87, 8'h32, 0, 0);
    irq_src_inst.hold_reset(60);
    #1 chk({7'h0, core_reset}, 8'h01);
    cyc(60);
    #1 chk({6'h0, osc_enable, core_reset}, 8'h02);
    rd(8'h87, 8'h30);
  endtask
  initial
  begin
    ref_clk = 1'h0;
    rst = 1'h1;
    {sfr_write, bit_write, bit_value, irq_ack, irq_return, latch_strobe_in} = 6'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    bit_index = 3'h0;
    cyc(20);
    rst <= 1'h0;
    t_regs;
    t_ext;
    t_poll;
    t_strobe;
    t_idle;
    t_pdown;
    end_sim;
  end
endmodule // irq_power_reset_control_tb
